// [testbench/fp_imm_flag_mul_properties.sv]
`timescale 1ns/1ns
module fp_imm_flag_mul_checker
   import fp_imm_flag_mul_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic issueValid,
   input wire logic [15:0] issueWord0,
   input wire logic [15:0] issueWord1,
   input wire logic [ST_W-1:0] statusWrMask,
   input wire logic [ST_W-1:0] statusWrVal,
   input wire logic [FL_W-1:0] floatFlags
);
   logic isXfer; // Flag transfer issued
   logic isMul; // Multiply issued
   logic isLoad; // Either immediate load issued
   logic busReq; // Bus request pending
   logic [4:0] selMask; // Status bits chosen by the mask
   logic [4:0] flagVal; // Status values the current flags imply
   assign isXfer = issueValid && issueWord0[15:8] == FLAG_XFER_OPC;
   assign isMul = issueValid && issueWord0 == MUL_OPC_W0
      && issueWord1[15:9] == MUL_OPC_W1_TOP;
   assign isLoad = issueValid && issueWord0[15:4] == LOAD_UPPER_OPC[12:1];
   assign busReq = cyc_i && stb_i;
   assign selMask = {{2{issueWord0[6]}}, issueWord0[3] | issueWord0[5],
      issueWord0[2] | issueWord0[4], issueWord0[0] | issueWord0[1]};
   assign flagVal = {{2{floatFlags[6]}}, floatFlags[3] | floatFlags[5],
      floatFlags[2] | floatFlags[4], floatFlags[0] | floatFlags[1]};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_xfer_mask: assert property (
      isXfer |=> statusWrMask == $past(selMask))
      else $error("status mask wrong");
   a_xfer_value: assert property (isXfer |=>
      ((statusWrVal ^ $past(flagVal)) & statusWrMask) == 5'h00)
      else $error("status value wrong");
   a_status_cause: assert property (
      statusWrMask != 5'h00 |-> $past(isXfer))
      else $error("status pulse without transfer");
   a_sticky_clear: assert property (
      isXfer && !$past(isMul) && !busReq |=>
      (floatFlags[1:0] & $past(issueWord0[1:0])) == 2'h0)
      else $error("sticky flag not cleared");
   a_load_flags: assert property (
      isLoad && !$past(isMul) && !busReq |=>
      $stable(floatFlags)) else $error("load changed flags");
   a_mul_keeps: assert property (isMul && !busReq ##1 !busReq |=>
      floatFlags[6:2] == $past(floatFlags[6:2], 2))
      else $error("multiply changed other flags");
   a_ack_answer: assert property (busReq && !ack_o |=> ack_o)
      else $error("no bus answer");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (ack_o |-> $past(busReq))
      else $error("ack without request");
   c_xfer: cover property (isXfer ##1 statusWrMask != 5'h00);
   c_mul_ovf: cover property (isMul ##2 floatFlags[FL_OVF]);
   c_bus: cover property (busReq ##1 ack_o);
endmodule
bind fp_imm_flag_mul fp_imm_flag_mul_checker u_chk (.ref_clk, .reset_n,
   .cyc_i, .stb_i, .ack_o, .issueValid, .issueWord0, .issueWord1,
   .statusWrMask, .statusWrVal, .floatFlags);

// [testbench/fp_imm_flag_mul_tb.sv]
`timescale 1ns/1ns
module fp_imm_flag_mul_tb;
   import fp_imm_flag_mul_pkg::*;
   logic ref_clk = 1'b0, reset_n = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
   logic we_i = 1'b0, ack_o, issueValid;
   logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic [15:0] issueWord0, issueWord1, h;
   logic [ST_W-1:0] statusWrMask, statusWrVal, stWant;
   logic [FL_W-1:0] floatFlags;
   logic [6:0] fTab [9] = '{7'h03, 7'h02, 7'h00, 7'h04, 7'h10, 7'h20,
      7'h40, 7'h00, 7'h7f};
   logic [7:0] mTab [9] = '{8'h01, 8'h02, 8'h03, 8'h10, 8'h04, 8'h08,
      8'h40, 8'h40, 8'h80};
   logic [4:0] m, v;
   int err_count = 0, samples_checked = 0;
   always #25 ref_clk = ~ref_clk;
   fp_imm_flag_mul DUT (.ref_clk(ref_clk), .reset_n(reset_n), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .issueValid(issueValid), .issueWord0(issueWord0),
      .issueWord1(issueWord1), .statusWrMask(statusWrMask),
      .statusWrVal(statusWrVal), .floatFlags(floatFlags));
   host_issue_model host (.ref_clk(ref_clk), .reset_n(reset_n),
      .issueValid(issueValid), .issueWord0(issueWord0),
      .issueWord1(issueWord1), .statusWrMask(statusWrMask),
      .statusWrVal(statusWrVal));
   task automatic complete_run();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Classic single Wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
      input logic [31:0] d);
      @(posedge ref_clk);
      {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
      // Wait for ack; only the watchdog ends a hung access
      do
         @(posedge ref_clk);
      while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      wb(1'b0, a, 4'hf, 32'h0);
      check(q, e);
   endtask
   task automatic setReg(input logic [2:0] r, input logic [31:0] d);
      wb(1'b1, REGSEL_OFF, 4'hf, {29'h0, r});
      wb(1'b1, REGDATA_OFF, 4'hf, d);
   endtask
   task automatic reg_is(input logic [2:0] r, input logic [31:0] e);
      wb(1'b1, REGSEL_OFF, 4'hf, {29'h0, r});
      rd(REGDATA_OFF, e);
   endtask
   task automatic ldu(input logic [2:0] r, input logic [15:0] i);
      host.issue({LOAD_UPPER_OPC, i[15:13]}, {i[12:0], r});
   endtask
   task automatic ldl(input logic [2:0] r, input logic [15:0] i);
      host.issue({LOAD_LOWER_OPC, i[15:13]}, {i[12:0], r});
   endtask
   task automatic mul(input logic [2:0] a, b, c);
      host.issue(MUL_OPC_W0, {MUL_OPC_W1_TOP, c, b, a});
   endtask
   // Hang guard, far beyond the few hundred cycles the run needs
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      complete_run();
   end
   initial
   begin
      stWant = 5'h00;
      repeat (5) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(FLAGS_OFF, 32'h0);
      rd(4'h2, 32'h0);
      reg_is(3'd7, 32'h0);
      for (int r = 7; r >= 0; r--)
         setReg(r[2:0], r == 0 ? 32'h807fffff : 32'hffffffff);
      rd(FLAGS_OFF, 32'h18);
      for (int r = 0; r < 8; r++)
      begin
         ldu(r[2:0], 16'hbfc0 ^ r[15:0]);
         if (r[0])
            ldl(r[2:0], 16'h0fdb + r[15:0]);
      end
      host.idle();
      rd(FLAGS_OFF, 32'h18);
      for (int r = 0; r < 8; r++)
      begin
         h = r[0] ? 16'h0fdb + r[15:0] : 16'h0000;
         reg_is(r[2:0], {16'hbfc0 ^ r[15:0], h});
      end
      ldu(3'd0, 16'h4000);
      ldu(3'd1, 16'h4040);
      mul(3'd2, 3'd0, 3'd1);
      ldl(3'd3, 16'h1234);
      host.idle();
      reg_is(3'd2, 32'h40c00000);
      ldu(3'd4, 16'h3f80);
      ldl(3'd4, 16'h0001);
      ldu(3'd5, 16'h3fc0);
      mul(3'd6, 3'd4, 3'd5);
      host.idle();
      reg_is(3'd6, 32'h3fc00002);
      wb(1'b1, CTRL_OFF, 4'hf, 32'h1);
      mul(3'd7, 3'd4, 3'd5);
      host.idle();
      reg_is(3'd7, 32'h3fc00001);
      wb(1'b1, CTRL_OFF, 4'hf, 32'h0);
      ldu(3'd0, 16'h7f00);
      ldu(3'd1, 16'h0080);
      mul(3'd2, 3'd0, 3'd0);
      mul(3'd3, 3'd1, 3'd1);
      host.idle();
      rd(FLAGS_OFF, 32'h1b);
      reg_is(3'd2, 32'h7f800000);
      reg_is(3'd3, 32'h0);
      for (int i = 0; i < 9; i++)
      begin
         wb(1'b1, FLAGS_OFF, 4'hf, {25'h0, fTab[i]});
         host.issue({FLAG_XFER_OPC, mTab[i]}, 16'h0000);
         host.idle();
         m = {{2{mTab[i][6]}}, mTab[i][3] | mTab[i][5],
            mTab[i][2] | mTab[i][4], mTab[i][0] | mTab[i][1]};
         v = {{2{fTab[i][6]}}, fTab[i][3] | fTab[i][5],
            fTab[i][2] | fTab[i][4], fTab[i][0] | fTab[i][1]};
         stWant = (stWant & ~m) | (v & m);
         rd(FLAGS_OFF, {25'h0, fTab[i] & ~{5'h00, mTab[i][1:0]}});
         check({27'h0, host.statusWordReg}, {27'h0, stWant});
         check(32'(host.statusWordReg[ST_OV]), 32'(stWant[ST_OV]));
         check(32'(host.statusWordReg[ST_N]), 32'(stWant[ST_N]));
         check(32'(host.statusWordReg[ST_Z]), 32'(stWant[ST_Z]));
         check(32'(host.statusWordReg[ST_TC]), 32'(stWant[ST_TC]));
      end
      wb(1'b1, FLAGS_OFF, 4'h3, 32'h0);
      rd(FLAGS_OFF, 32'h7f);
      check({25'h0, floatFlags}, 32'h7f);
      complete_run();
   end
endmodule

// [testbench/host_issue_model.sv]
`timescale 1ns/1ns
module host_issue_model
   import fp_imm_flag_mul_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   output logic issueValid,
   output logic [15:0] issueWord0,
   output logic [15:0] issueWord1,
   input wire logic [ST_W-1:0] statusWrMask,
   input wire logic [ST_W-1:0] statusWrVal
);
   logic [ST_W-1:0] statusWordReg; // Host status word zero
   logic [ST_W-1:0] statusWordNext;
   logic lastMul = 1'b0; // Previous slot held a multiply
   logic [2:0] mulDest = 3'h0; // Its destination
   initial
   begin
      issueValid = 1'b0;
      issueWord0 = 16'h0000;
      issueWord1 = 16'h0000;
   end
   // Idle slot: words toggle so stale values are never trusted
   task automatic idle();
      @(posedge ref_clk);
      issueValid <= 1'b0;
      issueWord0 <= ~issueWord0;
      issueWord1 <= ~issueWord1;
      lastMul = 1'b0;
   endtask
   // One instruction; a delay slot is padded where a hazard exists
   task automatic issue(input logic [15:0] w0, input logic [15:0] w1);
      if (lastMul && (w0[15:8] == FLAG_XFER_OPC || w1[2:0] == mulDest
         || w1[5:3] == mulDest || w1[8:6] == mulDest))
         idle();
      @(posedge ref_clk);
      issueValid <= 1'b1;
      issueWord0 <= w0;
      issueWord1 <= w1;
      lastMul = (w0 == MUL_OPC_W0);
      mulDest = w1[2:0];
   endtask
   // Only the masked status bits are updated
   always_comb
   begin
      statusWordNext = (statusWordReg & ~statusWrMask)
         | (statusWrVal & statusWrMask);
   end
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         statusWordReg <= '0;
      else
         statusWordReg <= statusWordNext;
   end
endmodule

// [verilog/fp_imm_flag_mul.sv]
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ns
module fp_imm_flag_mul
   import fp_imm_flag_mul_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset_n,
   // Classic Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Instruction issue from the host decode stage
   input wire logic issueValid,
   input wire logic [15:0] issueWord0,
   input wire logic [15:0] issueWord1,
   // Status word zero update towards the host
   output logic [fp_imm_flag_mul_pkg::ST_W-1:0] statusWrMask,
   output logic [fp_imm_flag_mul_pkg::ST_W-1:0] statusWrVal,
   // Current float status flags
   output logic [fp_imm_flag_mul_pkg::FL_W-1:0] floatFlags
);
   import fp_imm_flag_mul_pkg::*;

   // Decoded issue fields
   logic isUpper;
   logic isLower;
   logic isXfer;
   logic isMul;
   logic [15:0] immVal;
   logic [FP_SEL_W-1:0] dstSel;
   logic [FP_SEL_W-1:0] srcBSel;
   logic [FP_SEL_W-1:0] srcCSel;
   logic [7:0] xferMask;

   // Pipeline, flag and bus state
   logic mulPend_reg, mulPend_next;                  // Stage two valid
   logic [FP_SEL_W-1:0] mulDst_reg, mulDst_next;     // Stage two target
   logic [FL_W-1:0] flags_reg, flags_next;           // Float status flags
   logic [ST_W-1:0] stMask_reg, stMask_next;         // Status update mask
   logic [ST_W-1:0] stVal_reg, stVal_next;           // Status update value
   logic ctrlTrunc_reg, ctrlTrunc_next;              // Rounding mode
   logic [FP_SEL_W-1:0] regSel_reg, regSel_next;     // Bus register index
   logic ack_reg, ack_next;                          // Bus acknowledge
   logic [31:0] dat_reg, dat_next;                   // Bus read data

   // Register bank and multiplier wiring
   logic [31:0] opA;
   logic [31:0] opB;
   logic [31:0] bankRd;
   logic [31:0] product;
   logic mulOvf;
   logic mulUnf;
   logic bankHiEn;
   logic bankLoEn;
   logic [FP_SEL_W-1:0] bankAddr1;
   logic [31:0] bankData1;
   logic busReq;
   logic busWr;

   // Instruction field decode
   always_comb
   begin
      // Opcode matches only count while the issue slot is valid
      isUpper = issueValid && issueWord0[15:3] == LOAD_UPPER_OPC;
      isLower = issueValid && issueWord0[15:3] == LOAD_LOWER_OPC;
      isXfer = issueValid && issueWord0[15:8] == FLAG_XFER_OPC;
      isMul = issueValid && issueWord0 == MUL_OPC_W0
              && issueWord1[15:9] == MUL_OPC_W1_TOP;
      // Operand fields shared by the two-word forms
      immVal = {issueWord0[2:0], issueWord1[15:3]};
      dstSel = issueWord1[2:0];
      srcBSel = issueWord1[5:3];
      srcCSel = issueWord1[8:6];
      xferMask = issueWord0[7:0];
   end

   // A bus access is acknowledged on the cycle after it is seen
   assign busReq = cyc_i && stb_i && !ack_reg;
   // Writes need all four byte lanes; narrower ones are only acked
   assign busWr = busReq && we_i && sel_i == 4'hf;

   // Bank write port 1: immediate loads, else bus writes to REGDATA
   always_comb
   begin
      bankHiEn = 1'b0;
      bankLoEn = 1'b0;
      bankAddr1 = dstSel;
      bankData1 = 32'h00000000;
      // Upper load writes both halves so the low half clears
      if (isUpper)
      begin
         bankHiEn = 1'b1;
         bankLoEn = 1'b1;
         bankData1 = {immVal, 16'h0000};
      end
      else if (isLower)
      begin
         // Lower load leaves the high half alone
         bankLoEn = 1'b1;
         bankData1 = {16'h0000, immVal};
      end
      else if (busWr && adr_i == REGDATA_OFF)
      begin
         bankHiEn = 1'b1;
         bankLoEn = 1'b1;
         // Bus write of the indexed register, lowest priority
         bankAddr1 = regSel_reg;
         bankData1 = dat_i;
      end
   end

   // Eight float registers, sources read in the issue cycle
   fp_reg_bank #(
      .W(FP_W),
      .N(FP_REGS),
      .AW(FP_SEL_W)
   ) u_bank (
      .clk(ref_clk),
      .rstN(reset_n),
      .wrEn0(mulPend_reg),
      .wrAddr0(mulDst_reg),
      .wrData0(product),
      .wrHiEn1(bankHiEn),
      .wrLoEn1(bankLoEn),
      .wrAddr1(bankAddr1),
      .wrData1(bankData1),
      .rdAddrA(srcBSel),
      .rdAddrB(srcCSel),
      .rdAddrC(regSel_reg),
      .rdDataA(opA),
      .rdDataB(opB),
      .rdDataC(bankRd)
   );

   // Stage-two multiply on the registered operands
   fp_mul_core u_mul (
      .opA(opA),
      .opB(opB),
      .truncMode(ctrlTrunc_reg),
      .product(product),
      .overflow(mulOvf),
      .underflow(mulUnf)
   );

   // Multiply pipeline: operands caught at issue, written one cycle later
   always_comb
   begin
      // Stage-two valid lasts exactly one cycle
      mulPend_next = isMul;
      // Destination held until the next multiply
      mulDst_next = isMul ? dstSel : mulDst_reg;
   end

   // Float flags, status word update and flag transfer
   always_comb
   begin
      flags_next = flags_reg;
      // No status pulse unless a transfer issues
      stMask_next = '0;
      stVal_next = '0;
      // Software load of the flag register
      if (busWr && adr_i == FLAGS_OFF)
         flags_next = dat_i[FL_W-1:0];
      // Software load of a register refreshes the word-derived flags
      if (busWr && adr_i == REGDATA_OFF && !isUpper && !isLower)
      begin
         flags_next[FL_INEG] = dat_i[31];
         flags_next[FL_IZERO] = dat_i == 32'h00000000;
         flags_next[FL_FZERO] = dat_i[30:23] == 8'h00;
         flags_next[FL_FNEG] = dat_i[31] && dat_i[30:23] != 8'h00;
      end
      if (isXfer)
      begin
         // Overflow bit from either sticky flag
         if (xferMask[FL_OVF] || xferMask[FL_UNF])
         begin
            stMask_next[ST_OV] = 1'b1;
            stVal_next[ST_OV] = flags_reg[FL_OVF] || flags_reg[FL_UNF];
         end
         // Negative bit from either negative flag
         if (xferMask[FL_FNEG] || xferMask[FL_INEG])
         begin
            stMask_next[ST_N] = 1'b1;
            stVal_next[ST_N] = flags_reg[FL_FNEG] || flags_reg[FL_INEG];
         end
         // Zero bit from either zero flag
         if (xferMask[FL_FZERO] || xferMask[FL_IZERO])
         begin
            stMask_next[ST_Z] = 1'b1;
            stVal_next[ST_Z] = flags_reg[FL_FZERO] || flags_reg[FL_IZERO];
         end
         // Test flag feeds both carry and test bits
         if (xferMask[FL_TEST])
         begin
            stMask_next[ST_C] = 1'b1;
            stMask_next[ST_TC] = 1'b1;
            stVal_next[ST_C] = flags_reg[FL_TEST];
            stVal_next[ST_TC] = flags_reg[FL_TEST];
         end
         // Selected sticky flags are cleared on the way out
         if (xferMask[FL_OVF])
            flags_next[FL_OVF] = 1'b0;
         if (xferMask[FL_UNF])
            flags_next[FL_UNF] = 1'b0;
      end
      // Multiply events set the sticky flags last, so a set wins a clear
      if (mulPend_reg && mulUnf)
         flags_next[FL_UNF] = 1'b1;
      if (mulPend_reg && mulOvf)
         flags_next[FL_OVF] = 1'b1;
   end

   // Register file slave: control, flags, register index and data
   always_comb
   begin
      ctrlTrunc_next = ctrlTrunc_reg;
      regSel_next = regSel_reg;
      // One-cycle acknowledge for every taken access
      ack_next = busReq;
      dat_next = dat_reg;
      // Control and index registers take full-word writes
      if (busWr && adr_i == CTRL_OFF)
         ctrlTrunc_next = dat_i[CTRL_TRUNC];
      if (busWr && adr_i == REGSEL_OFF)
         regSel_next = dat_i[FP_SEL_W-1:0];
      // Read data is captured on the taking edge
      if (busReq && !we_i)
      begin
         case (adr_i)
            // Narrow registers read back in the low bits
            CTRL_OFF: dat_next = {31'h00000000, ctrlTrunc_reg};
            FLAGS_OFF: dat_next = {25'h0000000, flags_reg};
            REGSEL_OFF: dat_next = {29'h00000000, regSel_reg};
            REGDATA_OFF: dat_next = bankRd;
            default: dat_next = 32'h00000000;
         endcase
      end
   end

   // State registers
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         // Idle bus, no status pulse, nearest-even rounding
         mulPend_reg <= 1'b0;
         mulDst_reg <= '0;
         flags_reg <= FLAGS_RESET;
         stMask_reg <= '0;
         stVal_reg <= '0;
         ctrlTrunc_reg <= CTRL_RESET;
         regSel_reg <= '0;
         ack_reg <= 1'b0;
         dat_reg <= 32'h00000000;
      end
      else
      begin
         mulPend_reg <= mulPend_next;
         mulDst_reg <= mulDst_next;
         flags_reg <= flags_next;
         stMask_reg <= stMask_next;
         stVal_reg <= stVal_next;
         ctrlTrunc_reg <= ctrlTrunc_next;
         regSel_reg <= regSel_next;
         ack_reg <= ack_next;
         dat_reg <= dat_next;
      end
   end

   // Outputs, straight from flip-flops
   assign ack_o = ack_reg;
   assign dat_o = dat_reg;
   assign statusWrMask = stMask_reg;
   assign statusWrVal = stVal_reg;
   assign floatFlags = flags_reg;
endmodule

// [verilog/fp_imm_flag_mul_pkg.sv]
package fp_imm_flag_mul_pkg;
   // Float register file shape
   localparam int FP_REGS = 8;
   localparam int FP_SEL_W = 3;
   localparam int FP_W = 32;
   // Instruction word fields
   localparam logic [12:0] LOAD_UPPER_OPC = 13'h1d00;
   localparam logic [12:0] LOAD_LOWER_OPC = 13'h1d01;
   localparam logic [7:0] FLAG_XFER_OPC = 8'had;
   localparam logic [15:0] MUL_OPC_W0 = 16'he700;
   localparam logic [6:0] MUL_OPC_W1_TOP = 7'h00;
   // Float status flag positions (also the flag transfer mask layout)
   localparam int FL_OVF = 0;
   localparam int FL_UNF = 1;
   localparam int FL_FNEG = 2;
   localparam int FL_FZERO = 3;
   localparam int FL_INEG = 4;
   localparam int FL_IZERO = 5;
   localparam int FL_TEST = 6;
   localparam int FL_W = 7;
   localparam logic [FL_W-1:0] FLAGS_RESET = 7'h00;
   // CPU status word zero bit positions on the update port
   localparam int ST_OV = 0;
   localparam int ST_N = 1;
   localparam int ST_Z = 2;
   localparam int ST_C = 3;
   localparam int ST_TC = 4;
   localparam int ST_W = 5;
   // Single-precision format
   localparam int EXP_BIAS = 127;
   localparam logic [7:0] EXP_MAX = 8'hff;
   // Register map (byte addresses)
   localparam logic [3:0] CTRL_OFF = 4'h0;
   localparam logic [3:0] FLAGS_OFF = 4'h4;
   localparam logic [3:0] REGSEL_OFF = 4'h8;
   localparam logic [3:0] REGDATA_OFF = 4'hc;
   localparam int CTRL_TRUNC = 0;
   localparam logic CTRL_RESET = 1'b0;
endpackage

// [verilog/fp_mul_core.sv]
`timescale 1ns/1ns
module fp_mul_core
   import fp_imm_flag_mul_pkg::*;
(
   input wire logic [31:0] opA,
   input wire logic [31:0] opB,
   input wire logic truncMode,
   output logic [31:0] product,
   output logic overflow,
   output logic underflow
);
   logic sgn;
   logic [47:0] m;
   logic signed [9:0] e;
   logic [23:0] q;
   logic g;
   logic s;
   logic up;
   logic [24:0] r;

   // Combinational single-precision multiply; subnormal inputs read as zero
   always_comb
   begin
      sgn = opA[31] ^ opB[31];
      m = {1'b1, opA[22:0]} * {1'b1, opB[22:0]};
      e = $signed({2'h0, opA[30:23]}) + $signed({2'h0, opB[30:23]})
          - $signed(10'(EXP_BIAS));
      if (m[47])
      begin
         q = m[47:24];
         g = m[23];
         s = |m[22:0];
         e = e + 10'sd1;
      end
      else
      begin
         q = m[46:23];
         g = m[22];
         s = |m[21:0];
      end
      // Nearest-even unless truncation is configured
      up = !truncMode && g && (s || q[0]);
      r = {1'b0, q} + {24'h000000, up};
      if (r[24])
      begin
         q = r[24:1];
         e = e + 10'sd1;
      end
      else
         q = r[23:0];
      overflow = 1'b0;
      underflow = 1'b0;
      product = {sgn, e[7:0], q[22:0]};
      if (opA[30:23] == EXP_MAX || opB[30:23] == EXP_MAX)
         product = {sgn, EXP_MAX, 23'h000000};      // Infinite operand
      else if (opA[30:23] == 8'h00 || opB[30:23] == 8'h00)
         product = {sgn, 31'h00000000};             // Zero operand
      else if (e >= 10'sd255)
      begin
         overflow = 1'b1;
         product = {sgn, EXP_MAX, 23'h000000};
      end
      else if (e <= 10'sd0)
      begin
         underflow = 1'b1;
         product = {sgn, 31'h00000000};
      end
   end
endmodule

// [verilog/fp_reg_bank.sv]
`timescale 1ns/1ns
module fp_reg_bank #(
   parameter int W = 32,
   parameter int N = 8,
   parameter int AW = 3
) (
   input wire logic clk,
   input wire logic rstN,
   input wire logic wrEn0,
   input wire logic [AW-1:0] wrAddr0,
   input wire logic [W-1:0] wrData0,
   input wire logic wrHiEn1,
   input wire logic wrLoEn1,
   input wire logic [AW-1:0] wrAddr1,
   input wire logic [W-1:0] wrData1,
   input wire logic [AW-1:0] rdAddrA,
   input wire logic [AW-1:0] rdAddrB,
   input wire logic [AW-1:0] rdAddrC,
   output logic [W-1:0] rdDataA,
   output logic [W-1:0] rdDataB,
   output logic [W-1:0] rdDataC
);
   localparam int H = W / 2;
   logic [W-1:0] mem [N];      // Register contents

   // One storage word per entry; port 0 (full word) outranks port 1
   for (genvar i = 0; i < N; i++)
   begin : g_entry
      logic [W-1:0] entNext;
      always_comb
      begin
         entNext = mem[i];
         if (wrHiEn1 && wrAddr1 == AW'(i))
            entNext[W-1:H] = wrData1[W-1:H];
         if (wrLoEn1 && wrAddr1 == AW'(i))
            entNext[H-1:0] = wrData1[H-1:0];
         if (wrEn0 && wrAddr0 == AW'(i))
            entNext = wrData0;
      end
      always_ff @(posedge clk or negedge rstN)
      begin
         if (!rstN)
            mem[i] <= '0;
         else
            mem[i] <= entNext;
      end
   end

   // Registered read ports
   always_ff @(posedge clk or negedge rstN)
   begin
      if (!rstN)
      begin
         rdDataA <= '0;
         rdDataB <= '0;
         rdDataC <= '0;
      end
      else
      begin
         rdDataA <= mem[rdAddrA];
         rdDataB <= mem[rdAddrB];
         rdDataC <= mem[rdAddrC];
      end
   end
endmodule
